/* File: bench/pio_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pio_pad_model (
	input wire logic aclk,
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe,
	input wire logic [15:0] pull_up,
	input wire logic [15:0] pull_down,
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	output logic [15:0] pad_in
);
	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	logic [15:0] wander = 16'h5a5a;
	always @(posedge aclk) begin
		wander <= ~wander;
	end
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pull_up[i] | pull_down[i]) begin
				pad_in[i] = pull_up[i];
			end else begin
				pad_in[i] = wander[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/pio_pin_io_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module pio_pin_io_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] pad_oe,
	input wire logic [15:0] pull_down,
	input wire logic [15:0] pull_up,
	input wire logic [15:0] pull_strong,
	input wire logic sleep_mode,
	input wire logic wake_req,
	input wire logic aout_load,
	input wire logic [3:0] pin_edge_event,
	input wire logic irq
);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sequence s_b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence s_r_done;
		s_axi_rvalid && s_axi_rready;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read not answered");
	a_resp_holds: assert property ((s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		and (s_b_done |=> !s_axi_bvalid))
		else $error("write response dropped");
	a_rdata_holds: assert property ((s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		and (s_r_done |=> !s_axi_rvalid))
		else $error("read data dropped");
	a_pull_exclusive: assert property ((pull_up & pull_down) == 16'h0)
		else $error("pull up and down together");
	a_strong_pull: assert property ((pull_strong & ~(pull_up | pull_down)) == 16'h0)
		else $error("strong without pull");
	a_drive_no_pull: assert property ((pad_oe & (pull_up | pull_down)) == 16'h0)
		else $error("driven pin pulled");
	a_aout_with_resp: assert property (aout_load |-> s_axi_bvalid)
		else $error("analog load outside write");
	a_wake_sleep: assert property (!sleep_mode |=> !wake_req)
		else $error("wake while awake");
	a_event_single: assert property (pin_edge_event != 4'h0 |=>
		(pin_edge_event & $past(pin_edge_event)) == 4'h0)
		else $error("event pulse too long");
	a_irq_cause: assert property ($rose(irq) |->
		$past(pin_edge_event) != 4'h0 || s_axi_bvalid)
		else $error("irq without cause");
endmodule
bind pio_pin_io pio_pin_io_assertions u_pio_pin_io_assertions (.*);
`default_nettype wire

/* File: bench/pio_pin_io_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pio_pin_io_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef logic [31:0] pio_w_t;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic sleep_mode, wake_req, aout_load, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, adc_scale, rr;
	logic [3:0] s_axi_wstrb, adc_sel, aout_sel, pin_edge_event, ao_sel;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [9:0] adc_code;
	logic [15:0] pad_in, pad_out, pad_oe, pull_down, pull_up, pull_strong;
	logic [15:0] aout_value, ext_val, ao_val, snap;
	pio_w_t s_axi_wdata, s_axi_rdata, rv;
	int n_fail, checks_done, ao_cnt;
	int ev_cnt [4];
	logic [2:0] pulls [6] = '{3'h0, 3'h4, 3'h2, 3'h5, 3'h3, 3'h0};
	logic [7:0] scl [3] = '{8'h13, 8'h11, 8'h00};
	logic [1:0] sce [3] = '{2'h1, 2'h2, 2'h0};
	int ev_exp [4] = '{1, 1, 2, 0};
	always #2 aclk = ~aclk;
	pio_pin_io u_pio_pin_io (.*);
	pio_pad_model u_pio_pad_model (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pull_up(pull_up), .pull_down(pull_down), .ext_en(16'h0002), .ext_val(ext_val),
		.pad_in(pad_in));
	always @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			if (pin_edge_event[i] === 1'b1)
				ev_cnt[i]++;
		end
		if (aout_load === 1'b1) begin
			ao_cnt++;
			ao_sel = aout_sel;
			ao_val = aout_value;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input pio_w_t seen, input pio_w_t exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input pio_w_t d);
		int n;
		logic ok;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		ok = s_axi_bvalid;
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		if (!ok) begin
			n_fail++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		logic ok;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		ok = s_axi_rvalid;
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		if (!ok) begin
			n_fail++;
			end_sim();
		end
	endtask
	task automatic setf(input pio_w_t s, input pio_w_t f, input pio_w_t sb);
		wr(pio_pkg::REG_SIG, s);
		wr(pio_pkg::REG_FUNC, f);
		wr(pio_pkg::REG_SUB, sb);
		wr(pio_pkg::REG_CMD, 32'h1);
		rd(pio_pkg::REG_RESULT);
	endtask
	task automatic bnd(input pio_w_t c, input pio_w_t s, input pio_w_t p);
		wr(pio_pkg::REG_CHAN, c);
		wr(pio_pkg::REG_SIG, s);
		wr(pio_pkg::REG_POL, p);
		wr(pio_pkg::REG_CMD, 32'h3);
		rd(pio_pkg::REG_RESULT);
	endtask
	task automatic pw(input pio_w_t s, input pio_w_t v);
		wr(pio_pkg::REG_SIG, s);
		wr(pio_pkg::REG_VAL, v);
		wr(pio_pkg::REG_CMD, 32'h2);
	endtask
	task automatic prd(input pio_w_t s);
		wr(pio_pkg::REG_SIG, s);
		rd(pio_pkg::REG_READ);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_val, sleep_mode} = 65'h0;
		s_axi_wstrb = 4'hf;
		adc_code = 10'h2a5;
		ao_cnt = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(pio_pkg::REG_RESULT);
		chk("result", rv, 32'h0);
		rd(8'h38);
		chk("unmapped", {rv[29:0], rr}, 32'(pio_pkg::RESP_SLVERR));
		wr(8'h38, 0);
		chk("wr resp", rr, 32'(pio_pkg::RESP_SLVERR));
		for (int f = 0; f < 7; f++) begin
			setf(5, f, 0);
			chk("func", rv, (f > 0 && f < 6) ? 32'h0 : 32'(pio_pkg::RES_BAD_FUNC));
		end
		for (int s = 1; s < 6; s++) begin
			setf(6, 1, s);
			chk("pull", {pull_down[6], pull_up[6], pull_strong[6]}, pulls[s]);
		end
		setf(6, 1, 32'h100);
		chk("sub high", rv, 32'(pio_pkg::RES_BAD_SUB));
		setf(2, 2, 1);
		chk("init high", {pad_oe[2], pad_out[2]}, 2'h3);
		pw(2, 0);
		chk("wr zero", pad_out[2], 1'b0);
		pw(2, 32'h80);
		chk("wr one", pad_out[2], 1'b1);
		repeat (4) @(posedge aclk);
		prd(2);
		chk("rd pin", rv, 32'h1);
		setf(2, 2, 0);
		chk("init low", pad_out[2], 1'b0);
		snap = pad_out;
		pw(16, 1);
		chk("bad wr", {ao_cnt[15:0], pad_out}, {16'h0, snap});
		prd(16);
		chk("bad rd", rv, 32'h0);
		setf(16, 1, 0);
		chk("bad sig", rv, 32'(pio_pkg::RES_BAD_SIG));
		setf(3, 5, 0);
		pw(3, 32'h1234beef);
		chk("aout", {ao_cnt[3:0], ao_sel, ao_val}, 24'h13beef);
		for (int k = 0; k < 3; k++) begin
			setf(7 + k, 3, scl[k]);
			chk("scale", adc_scale, sce[k]);
		end
		prd(9);
		chk("adc", rv, 32'h2a5);
		chk("adc sel", adc_sel, 4'h9);
		setf(1, 1, 32'h20);
		for (int c = 0; c < 4; c++) begin
			bnd(c, 1, c % 3);
			chk("bind", rv, 32'h0);
		end
		wr(pio_pkg::REG_CHAN, 3);
		wr(pio_pkg::REG_CMD, 32'h4);
		rd(pio_pkg::REG_RESULT);
		chk("unbind", rv, 32'h0);
		wr(pio_pkg::REG_IMASK, 32'h1);
		sleep_mode <= 1'b1;
		ev_cnt = '{default: 0};
		ext_val <= 16'h0002;
		repeat (10) @(posedge aclk);
		chk("wake", wake_req, 1'b1);
		chk("irq", irq, 1'b1);
		rd(pio_pkg::REG_ISTAT);
		chk("status", rv, 32'h5);
		wr(pio_pkg::REG_ISTAT, 32'h1);
		chk("irq clr", irq, 1'b0);
		ext_val <= 16'h0;
		repeat (10) @(posedge aclk);
		chk("masked", irq, 1'b0);
		for (int c = 0; c < 4; c++)
			chk("events", ev_cnt[c], ev_exp[c]);
		sleep_mode <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("wake clr", wake_req, 1'b0);
		bnd(4, 1, 0);
		chk("bad chan", rv, 32'(pio_pkg::RES_BAD_CHAN));
		bnd(0, 2, 0);
		chk("not input", rv, 32'(pio_pkg::RES_NOT_DIN));
		bnd(0, 1, 3);
		chk("bad pol", rv, 32'(pio_pkg::RES_BAD_POL));
		wr(pio_pkg::REG_CMD, 7);
		rd(pio_pkg::REG_RESULT);
		chk("bad cmd", rv, 32'(pio_pkg::RES_BAD_CMD));
		end_sim();
	end
endmodule
`default_nettype wire

/* File: core/pio_edge_chan.sv */
`timescale 1ns/1ns
`default_nettype none
module pio_edge_chan (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pio_pkg::NUM_PINS-1:0] levels,
	input wire pio_pkg::pio_chan_cfg_s cfg,
	output logic pin_edge_event
);
	typedef struct packed {
		logic prev;
		logic armed;
		logic [pio_pkg::SIG_W-1:0] last_sig;
		logic pulse;
	} pio_chan_s;
	pio_chan_s s;
	pio_chan_s next_s;
	logic cur;
	logic rise;
	logic fall;
	// ----------------------------------------
	// Edge compare against previous sample
	// ----------------------------------------
	always_comb begin
		next_s = s;
		cur = levels[cfg.sig];
		rise = cur & ~s.prev;
		fall = ~cur & s.prev;
		next_s.pulse = 1'b0;
		if (cfg.en && s.armed && (cfg.sig == s.last_sig)) begin
			case (cfg.pol)
				pio_pkg::POL_RISE: next_s.pulse = rise;
				pio_pkg::POL_FALL: next_s.pulse = fall;
				pio_pkg::POL_BOTH: next_s.pulse = rise | fall;
				default: next_s.pulse = 1'b0;
			endcase
		end
		next_s.prev = cur;
		next_s.last_sig = cfg.sig;
		next_s.armed = cfg.en;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign pin_edge_event = s.pulse;
endmodule
`default_nettype wire

/* File: core/pio_pin_io.sv */
// Functional notes
// - Pin function select codes one to five
// - Digital input pull from low nibble
// - Digital input wake edge from nibble two
// - Digital output starts at chosen level
// - Analog input scaling shared by all
// - Read gives level, code, or zero
// - Write to bad pin changes nothing
// - Digital write: zero low, else high
// - Analog write passes value to pin
// - Four edge channels raise own events
// - Polarity rise, fall or both
// - Unbound channel raises no event
// - Commands other than write report result, zero is success
`timescale 1ns/1ns
`default_nettype none
module pio_pin_io (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pio_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pio_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [pio_pkg::NUM_PINS-1:0] pad_in,
	output logic [pio_pkg::NUM_PINS-1:0] pad_out,
	output logic [pio_pkg::NUM_PINS-1:0] pad_oe,
	output logic [pio_pkg::NUM_PINS-1:0] pull_down,
	output logic [pio_pkg::NUM_PINS-1:0] pull_up,
	output logic [pio_pkg::NUM_PINS-1:0] pull_strong,
	input wire logic sleep_mode,
	output logic wake_req,
	output logic [pio_pkg::SIG_W-1:0] adc_sel,
	input wire logic [pio_pkg::ADC_W-1:0] adc_code,
	output logic [1:0] adc_scale,
	output logic [pio_pkg::SIG_W-1:0] aout_sel,
	output logic [pio_pkg::AOUT_W-1:0] aout_value,
	output logic aout_load,
	output logic [pio_pkg::NUM_CHAN-1:0] pin_edge_event,
	output logic irq
);
	typedef struct packed {
		pio_pkg::pio_pin_cfg_s [pio_pkg::NUM_PINS-1:0] cfg;
		pio_pkg::pio_chan_cfg_s [pio_pkg::NUM_CHAN-1:0] chan;
		logic [7:0] arg_sig;
		logic [2:0] arg_func;
		logic [31:0] arg_sub;
		logic [31:0] arg_val;
		logic [7:0] arg_chan;
		logic [1:0] arg_pol;
		logic [15:0] result;
		pio_pkg::pio_scale_e scale;
		logic [pio_pkg::NUM_CHAN-1:0] int_status;
		logic [pio_pkg::NUM_CHAN-1:0] int_mask;
		logic irq;
		logic [pio_pkg::NUM_PINS-1:0] prev_lvl;
		logic wake;
		logic [pio_pkg::NUM_PINS-1:0] pad_out;
		logic [pio_pkg::NUM_PINS-1:0] pad_oe;
		logic [pio_pkg::NUM_PINS-1:0] pull_down;
		logic [pio_pkg::NUM_PINS-1:0] pull_up;
		logic [pio_pkg::NUM_PINS-1:0] pull_strong;
		logic [pio_pkg::SIG_W-1:0] aout_sel;
		logic [pio_pkg::AOUT_W-1:0] aout_value;
		logic aout_load;
		logic aw_hold;
		logic w_hold;
		logic [pio_pkg::ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pio_top_s;
	pio_top_s s;
	pio_top_s next_s;
	logic [pio_pkg::NUM_PINS-1:0] lvl;
	logic [pio_pkg::NUM_CHAN-1:0] evt;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] word_addr(input logic [pio_pkg::ADDR_W-1:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		if (w > pio_pkg::REG_BINDS) begin
			w = pio_pkg::REG_NONE;
		end
		return w;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction
	function automatic logic sub_ok(input pio_pkg::pio_func_e f, input logic [31:0] sub);
		logic ok;
		ok = 1'b1;
		case (f)
			pio_pkg::FN_DIN: ok = (sub[31:8] == 24'h000000);
			pio_pkg::FN_DOUT: ok = (sub[31:1] == 31'h00000000);
			pio_pkg::FN_AIN: ok = (sub == {24'h000000, pio_pkg::AIN_SUB_DEF})
				|| (sub == {24'h000000, pio_pkg::AIN_SUB_THIRD})
				|| (sub == {24'h000000, pio_pkg::AIN_SUB_UNITY});
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction
	// ----------------------------------------
	// Pin synchronisers and edge channels
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pio_pkg::NUM_PINS; gi++) begin : g_sync
			pio_pin_sync u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin(pad_in[gi]),
				.level(lvl[gi])
			);
		end
		for (gi = 0; gi < pio_pkg::NUM_CHAN; gi++) begin : g_chan
			pio_edge_chan u_chan (
				.aclk(aclk),
				.aresetn(aresetn),
				.levels(lvl),
				.cfg(s.chan[gi]),
				.pin_edge_event(evt[gi])
			);
		end
	endgenerate
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic [7:0] wa;
	logic [7:0] ra;
	logic do_wr;
	logic sig_ok;
	logic chan_ok;
	logic [pio_pkg::SIG_W-1:0] sig;
	logic [1:0] ch;
	pio_pkg::pio_func_e fsel;
	logic [31:0] rd;
	always_comb begin
		next_s = s;
		wa = 8'h00;
		ra = 8'h00;
		do_wr = 1'b0;
		sig = s.arg_sig[pio_pkg::SIG_W-1:0];
		ch = s.arg_chan[1:0];
		sig_ok = (s.arg_sig < 8'(pio_pkg::NUM_PINS));
		chan_ok = (s.arg_chan < 8'(pio_pkg::NUM_CHAN));
		fsel = pio_pkg::pio_func_e'(s.arg_func);
		rd = 32'h00000000;
		next_s.aout_load = 1'b0;
		// Write channels taken in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_hold = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_hold = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		do_wr = next_s.aw_hold && next_s.w_hold && !s.bvalid;
		if (do_wr) begin
			wa = word_addr(next_s.awaddr);
			next_s.aw_hold = 1'b0;
			next_s.w_hold = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = pio_pkg::RESP_OKAY;
			case (wa)
				pio_pkg::REG_SIG: next_s.arg_sig = 8'(merge({24'h0, s.arg_sig},
					next_s.wdata, next_s.wstrb));
				pio_pkg::REG_FUNC: begin
					if (next_s.wstrb[0]) begin
						next_s.arg_func = next_s.wdata[2:0];
					end
				end
				pio_pkg::REG_SUB: next_s.arg_sub = merge(s.arg_sub, next_s.wdata,
					next_s.wstrb);
				pio_pkg::REG_VAL: next_s.arg_val = merge(s.arg_val, next_s.wdata,
					next_s.wstrb);
				pio_pkg::REG_CHAN: begin
					if (next_s.wstrb[0]) begin
						next_s.arg_chan = next_s.wdata[7:0];
					end
				end
				pio_pkg::REG_POL: begin
					if (next_s.wstrb[0]) begin
						next_s.arg_pol = next_s.wdata[1:0];
					end
				end
				pio_pkg::REG_CMD: begin
					if (next_s.wstrb[0]) begin
						case (pio_pkg::pio_cmd_e'(next_s.wdata[2:0]))
							pio_pkg::CMD_SET_FUNC: begin
								if (!sig_ok) begin
									next_s.result = pio_pkg::RES_BAD_SIG;
								end else if (fsel == pio_pkg::FN_NONE
									|| s.arg_func > 3'(pio_pkg::FN_AOUT)) begin
									next_s.result = pio_pkg::RES_BAD_FUNC;
								end else if (!sub_ok(fsel, s.arg_sub)) begin
									next_s.result = pio_pkg::RES_BAD_SUB;
								end else begin
									next_s.cfg[sig].func = fsel;
									next_s.cfg[sig].sub = s.arg_sub[7:0];
									if (fsel == pio_pkg::FN_DOUT) begin
										next_s.cfg[sig].out_lvl = s.arg_sub[0];
									end
									if (fsel == pio_pkg::FN_AIN) begin
										case (s.arg_sub[7:0])
											pio_pkg::AIN_SUB_THIRD: next_s.scale = pio_pkg::SC_THIRD;
											pio_pkg::AIN_SUB_UNITY: next_s.scale = pio_pkg::SC_UNITY;
											default: next_s.scale = pio_pkg::SC_TWO_THIRDS;
										endcase
									end
									next_s.result = pio_pkg::RES_OK;
								end
							end
							pio_pkg::CMD_WRITE: begin
								if (sig_ok) begin
									case (s.cfg[sig].func)
										pio_pkg::FN_DIN, pio_pkg::FN_DOUT: begin
											next_s.cfg[sig].out_lvl = |s.arg_val;
										end
										pio_pkg::FN_AIN, pio_pkg::FN_AREF, pio_pkg::FN_AOUT: begin
											next_s.aout_load = 1'b1;
											next_s.aout_sel = sig;
											next_s.aout_value = s.arg_val[pio_pkg::AOUT_W-1:0];
										end
										default: next_s.aout_load = 1'b0;
									endcase
								end
							end
							pio_pkg::CMD_BIND: begin
								if (!chan_ok) begin
									next_s.result = pio_pkg::RES_BAD_CHAN;
								end else if (!sig_ok) begin
									next_s.result = pio_pkg::RES_BAD_SIG;
								end else if (s.cfg[sig].func != pio_pkg::FN_DIN) begin
									next_s.result = pio_pkg::RES_NOT_DIN;
								end else if (s.arg_pol > 2'(pio_pkg::POL_BOTH)) begin
									next_s.result = pio_pkg::RES_BAD_POL;
								end else begin
									next_s.chan[ch].en = 1'b1;
									next_s.chan[ch].sig = sig;
									next_s.chan[ch].pol = pio_pkg::pio_pol_e'(s.arg_pol);
									next_s.result = pio_pkg::RES_OK;
								end
							end
							pio_pkg::CMD_UNBIND: begin
								if (!chan_ok) begin
									next_s.result = pio_pkg::RES_BAD_CHAN;
								end else begin
									next_s.chan[ch].en = 1'b0;
									next_s.result = pio_pkg::RES_OK;
								end
							end
							default: next_s.result = pio_pkg::RES_BAD_CMD;
						endcase
					end
				end
				pio_pkg::REG_ISTAT: begin
					if (next_s.wstrb[0]) begin
						next_s.int_status = s.int_status & ~next_s.wdata[3:0];
					end
				end
				pio_pkg::REG_IMASK: begin
					if (next_s.wstrb[0]) begin
						next_s.int_mask = next_s.wdata[3:0];
					end
				end
				pio_pkg::REG_RESULT, pio_pkg::REG_READ, pio_pkg::REG_SCALE,
				pio_pkg::REG_LEVELS, pio_pkg::REG_BINDS: next_s.bresp = pio_pkg::RESP_OKAY;
				default: next_s.bresp = pio_pkg::RESP_SLVERR;
			endcase
		end
		next_s.awready = !next_s.aw_hold && !next_s.bvalid;
		next_s.wready = !next_s.w_hold && !next_s.bvalid;
		// Events set after clears so a set wins
		next_s.int_status = next_s.int_status | evt;
		next_s.irq = |(next_s.int_status & next_s.int_mask);
		// Read channel
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			ra = word_addr(s_axi_araddr);
			next_s.rresp = pio_pkg::RESP_OKAY;
			case (ra)
				pio_pkg::REG_SIG: rd = {24'h000000, s.arg_sig};
				pio_pkg::REG_FUNC: rd = {29'h00000000, s.arg_func};
				pio_pkg::REG_SUB: rd = s.arg_sub;
				pio_pkg::REG_VAL: rd = s.arg_val;
				pio_pkg::REG_CHAN: rd = {24'h000000, s.arg_chan};
				pio_pkg::REG_POL: rd = {30'h00000000, s.arg_pol};
				pio_pkg::REG_CMD: rd = 32'h00000000;
				pio_pkg::REG_RESULT: rd = {16'h0000, s.result};
				pio_pkg::REG_READ: begin
					if (sig_ok) begin
						case (s.cfg[sig].func)
							pio_pkg::FN_DIN, pio_pkg::FN_DOUT: rd = {31'h0, lvl[sig]};
							pio_pkg::FN_AIN: rd = {22'h000000, adc_code};
							default: rd = 32'h00000000;
						endcase
					end
				end
				pio_pkg::REG_ISTAT: rd = {28'h0000000, s.int_status};
				pio_pkg::REG_IMASK: rd = {28'h0000000, s.int_mask};
				pio_pkg::REG_SCALE: rd = {30'h00000000, s.scale};
				pio_pkg::REG_LEVELS: rd = {16'h0000, lvl};
				pio_pkg::REG_BINDS: begin
					for (int c = 0; c < pio_pkg::NUM_CHAN; c++) begin
						rd[c*8 +: 8] = {s.chan[c].en, s.chan[c].pol, 1'b0, s.chan[c].sig};
					end
				end
				default: next_s.rresp = pio_pkg::RESP_SLVERR;
			endcase
			next_s.rvalid = 1'b1;
			next_s.rdata = rd;
		end
		next_s.arready = !next_s.rvalid;
		// Pads, pulls and wake from pin configuration
		if (!sleep_mode) begin
			next_s.wake = 1'b0;
		end
		for (int i = 0; i < pio_pkg::NUM_PINS; i++) begin
			next_s.pad_oe[i] = (next_s.cfg[i].func == pio_pkg::FN_DOUT);
			next_s.pad_out[i] = next_s.cfg[i].out_lvl;
			next_s.pull_down[i] = 1'b0;
			next_s.pull_up[i] = 1'b0;
			next_s.pull_strong[i] = 1'b0;
			if (next_s.cfg[i].func == pio_pkg::FN_DIN) begin
				case (next_s.cfg[i].sub[3:0])
					pio_pkg::PULL_WEAK_DN: next_s.pull_down[i] = 1'b1;
					pio_pkg::PULL_WEAK_UP: next_s.pull_up[i] = 1'b1;
					pio_pkg::PULL_STRONG_DN: begin
						next_s.pull_down[i] = 1'b1;
						next_s.pull_strong[i] = 1'b1;
					end
					pio_pkg::PULL_STRONG_UP: begin
						next_s.pull_up[i] = 1'b1;
						next_s.pull_strong[i] = 1'b1;
					end
					default: next_s.pull_strong[i] = 1'b0;
				endcase
				if (sleep_mode) begin
					if (s.cfg[i].sub[7:4] == pio_pkg::WAKE_FALL && s.prev_lvl[i] && !lvl[i]) begin
						next_s.wake = 1'b1;
					end
					if (s.cfg[i].sub[7:4] == pio_pkg::WAKE_RISE && !s.prev_lvl[i] && lvl[i]) begin
						next_s.wake = 1'b1;
					end
				end
			end
		end
		next_s.prev_lvl = lvl;
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign pad_out = s.pad_out;
	assign pad_oe = s.pad_oe;
	assign pull_down = s.pull_down;
	assign pull_up = s.pull_up;
	assign pull_strong = s.pull_strong;
	assign wake_req = s.wake;
	assign adc_sel = s.arg_sig[pio_pkg::SIG_W-1:0];
	assign adc_scale = s.scale;
	assign aout_sel = s.aout_sel;
	assign aout_value = s.aout_value;
	assign aout_load = s.aout_load;
	assign pin_edge_event = evt;
	assign irq = s.irq;
endmodule
`default_nettype wire

/* File: core/pio_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pio_pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} pio_sync_s;
	pio_sync_s s;
	pio_sync_s next_s;
	// ----------------------------------------
	// Three stages, level moves when two and three agree
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		if (s.s2 == s.s3) begin
			next_s.lvl = s.s3;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign level = s.lvl;
endmodule
`default_nettype wire

/* File: core/pio_pkg.sv */
`default_nettype none
package pio_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_PINS = 16;
	localparam int SIG_W = 4;
	localparam int NUM_CHAN = 4;
	localparam int ADC_W = 10;
	localparam int AOUT_W = 16;
	localparam int ADDR_W = 8;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] REG_SIG = 8'h00;
	localparam logic [7:0] REG_FUNC = 8'h04;
	localparam logic [7:0] REG_SUB = 8'h08;
	localparam logic [7:0] REG_VAL = 8'h0c;
	localparam logic [7:0] REG_CHAN = 8'h10;
	localparam logic [7:0] REG_POL = 8'h14;
	localparam logic [7:0] REG_CMD = 8'h18;
	localparam logic [7:0] REG_RESULT = 8'h1c;
	localparam logic [7:0] REG_READ = 8'h20;
	localparam logic [7:0] REG_ISTAT = 8'h24;
	localparam logic [7:0] REG_IMASK = 8'h28;
	localparam logic [7:0] REG_SCALE = 8'h2c;
	localparam logic [7:0] REG_LEVELS = 8'h30;
	localparam logic [7:0] REG_BINDS = 8'h34;
	localparam logic [7:0] REG_NONE = 8'hff;
	// ----------------------------------------
	// Result codes
	// ----------------------------------------
	localparam logic [15:0] RES_OK = 16'h0000;
	localparam logic [15:0] RES_BAD_SIG = 16'h0001;
	localparam logic [15:0] RES_BAD_FUNC = 16'h0002;
	localparam logic [15:0] RES_BAD_SUB = 16'h0003;
	localparam logic [15:0] RES_BAD_CHAN = 16'h0004;
	localparam logic [15:0] RES_NOT_DIN = 16'h0005;
	localparam logic [15:0] RES_BAD_POL = 16'h0006;
	localparam logic [15:0] RES_BAD_CMD = 16'h0007;
	// ----------------------------------------
	// Sub-function fields and bus response codes
	// ----------------------------------------
	localparam logic [3:0] PULL_WEAK_DN = 4'h1;
	localparam logic [3:0] PULL_WEAK_UP = 4'h2;
	localparam logic [3:0] PULL_STRONG_DN = 4'h3;
	localparam logic [3:0] PULL_STRONG_UP = 4'h4;
	localparam logic [3:0] WAKE_FALL = 4'h1;
	localparam logic [3:0] WAKE_RISE = 4'h2;
	localparam logic [7:0] AIN_SUB_DEF = 8'h00;
	localparam logic [7:0] AIN_SUB_THIRD = 8'h13;
	localparam logic [7:0] AIN_SUB_UNITY = 8'h11;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		FN_NONE = 3'b000,
		FN_DIN = 3'b001,
		FN_DOUT = 3'b010,
		FN_AIN = 3'b011,
		FN_AREF = 3'b100,
		FN_AOUT = 3'b101
	} pio_func_e;
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_SET_FUNC = 3'b001,
		CMD_WRITE = 3'b010,
		CMD_BIND = 3'b011,
		CMD_UNBIND = 3'b100
	} pio_cmd_e;
	typedef enum logic [1:0] {
		POL_RISE = 2'b00,
		POL_FALL = 2'b01,
		POL_BOTH = 2'b10
	} pio_pol_e;
	typedef enum logic [1:0] {
		SC_TWO_THIRDS = 2'b00,
		SC_THIRD = 2'b01,
		SC_UNITY = 2'b10
	} pio_scale_e;
	typedef struct packed {
		pio_func_e func;
		logic [7:0] sub;
		logic out_lvl;
	} pio_pin_cfg_s;
	typedef struct packed {
		logic en;
		logic [SIG_W-1:0] sig;
		pio_pol_e pol;
	} pio_chan_cfg_s;
endpackage
`default_nettype wire
